//--- tcs_regs.vh
// Register offsets, field positions, reset values and timing counts of the touch controller port
`ifndef TCS_REGS_VH
`define TCS_REGS_VH
`define TCS_OFF_SENSE_EN      8'h07
`define TCS_OFF_OUT_EN        8'h08
`define TCS_OFF_STRONG        8'h11
`define TCS_OFF_SETTLE        8'h50
`define TCS_OFF_OTHER         8'h51
`define TCS_OFF_SCAN0         8'h5c
`define TCS_OFF_SCAN1         8'h5d
`define TCS_OFF_OUT_PORT      8'h04
`define TCS_OFF_ADDR_DM       8'h7c
`define TCS_OFF_STATUS        8'h7b
`define TCS_OFF_BUTTONS       8'h88
`define TCS_OFF_CMD           8'ha0
`define TCS_CMD_STOP_SCAN     8'h0a
`define TCS_CMD_START_SCAN    8'h0b
`define TCS_CMD_SETUP_ENTER   8'h08
`define TCS_CMD_SETUP_LEAVE   8'h07
`define TCS_CMD_SAVE          8'h01
`define TCS_ADDR_DEFAULT      7'h00
`define TCS_RST_SENSE_EN      8'h03
`define TCS_RST_OUT_EN        8'h03
`define TCS_RST_STRONG        8'h03
`define TCS_RST_SETTLE        8'ha0
`define TCS_RST_OTHER         8'h00
`define TCS_RST_SCAN0         8'h00
`define TCS_RST_SCAN1         8'h01
`define TCS_RST_OUT_PORT      8'h03
`define TCS_RST_ADDR_DM       8'h80
`define TCS_ADDR_DM_SRC_BIT   7
`define TCS_CLK_HZ            10000000
`define TCS_ACK_NORM_US       20
`define TCS_ACK_SETUP_US      2000
`define TCS_ACK_NORM_CYC      ((`TCS_ACK_NORM_US * (`TCS_CLK_HZ / 1000000)))
`define TCS_ACK_SETUP_CYC     ((`TCS_ACK_SETUP_US * (`TCS_CLK_HZ / 1000000)))
`endif

//--- tcs_sync.v
// Two-flip-flop synchroniser for one pin
`default_nettype none
module tcs_sync
(
  input  wire clk,
  input  wire rst_n,
  input  wire d,
  output reg  q
);
  reg meta_r;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b1;
      q      <= 1'b1;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // tcs_sync
`default_nettype wire

//--- tcs_stretch.v
// Acknowledge hold timer: counts the processing time of one byte
`default_nettype none
module tcs_stretch
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        start,
  input  wire [15:0] cycles,
  output wire        busy
);
  reg [15:0] cnt_r;
  assign busy = (cnt_r != 16'h0000);
  always @(posedge clk)
  begin
    if (!rst_n)
      cnt_r <= 16'h0000;
    else if (start)
      cnt_r <= cycles;
    else if (busy)
      cnt_r <= cnt_r - 16'h0001;
  end
endmodule // tcs_stretch
`default_nettype wire

//--- tcs_slave.v
// Two-wire slave port with register file of the touch controller
//
// Behaviour
// - Normal mode: setup-only registers 07,08,11,50,51,5C,5D are read-only.
// - Normal mode acknowledge hold is short and fixed, independent of configuration.
// - Setup mode: every non-read-only register is writable; all but 04 and A0 are readable (those read back as zero).
// - Setup mode may hold the acknowledge longer than normal mode.
// - Command 0x0A at 0xA0 stops scanning; setup latency then drops to normal.
// - Device answers its own seven-bit slave address.
// - Address byte bit 0: zero is master write, one is master read.
// - After each received byte the clock is held low until processed.
// - Slave address is changeable over the bus, no strap pins.
// - Outputs follow sensor inputs by default, or register writes when configured.
// - Configuration can be saved to storage and reloaded at power-up.
// - Port works at bit rates up to 400 kbps.
// - Per-byte stretch stays within the maximum acknowledge times.
`default_nettype none
`include "tcs_regs.vh"
module tcs_slave
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        scl_i,
  output wire        scl_o,
  output wire        scl_oe_n,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_n,
  input  wire [1:0]  sense_state,
  output reg  [1:0]  out_pins,
  output reg         scan_en,
  output reg         setup_mode,
  output reg         save_req,
  input  wire        save_done,
  input  wire        load_valid,
  input  wire [63:0] load_image
);
  localparam ST_IDLE = 3'd0;
  localparam ST_RX   = 3'd1;
  localparam ST_HOLD = 3'd2;
  localparam ST_ACK  = 3'd3;
  localparam ST_TX   = 3'd4;
  localparam ST_RACK = 3'd5;

  wire scl_s;
  wire sda_s;
  reg  scl_d_r;
  reg  sda_d_r;
  tcs_sync u_scl (.clk(clk), .rst_n(rst_n), .d(scl_i), .q(scl_s));
  tcs_sync u_sda (.clk(clk), .rst_n(rst_n), .d(sda_i), .q(sda_s));

  // Edges of the synchronised pins; 10 MHz sampling keeps up with 400 kbps
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

  reg [2:0] st_r;
  reg [2:0] bit_r;
  reg [7:0] sh_r;
  reg       first_r;
  reg       rd_r;
  reg       ptr_ok_r;
  reg [7:0] ptr_r;
  reg       hit_r;
  reg       sda_low_r;
  reg       hold_start_r;

  reg [7:0] sense_en_r;
  reg [7:0] out_en_r;
  reg [7:0] strong_r;
  reg [7:0] settle_r;
  reg [7:0] other_r;
  reg [7:0] scan0_r;
  reg [7:0] scan1_r;
  reg [7:0] out_port_r;
  reg [7:0] addr_dm_r;
  reg [7:0] rdata;

  wire hold_busy;
  // Long hold only in setup mode while scanning runs
  localparam [31:0] HOLD_NORM  = `TCS_ACK_NORM_CYC;
  localparam [31:0] HOLD_SETUP = `TCS_ACK_SETUP_CYC;
  wire [15:0] hold_cyc = (setup_mode && scan_en) ? HOLD_SETUP[15:0]
                                                 : HOLD_NORM[15:0];
  tcs_stretch u_hold (.clk(clk), .rst_n(rst_n), .start(hold_start_r), .cycles(hold_cyc),
                      .busy(hold_busy));

  // Clock held low while a received byte is processed
  assign scl_o    = 1'b0;
  assign scl_oe_n = ~((st_r == ST_HOLD) && !scl_s);
  assign sda_o    = 1'b0;
  assign sda_oe_n = ~sda_low_r;

  always @*
  begin
    case (ptr_r)
      `TCS_OFF_SENSE_EN: rdata = sense_en_r;
      `TCS_OFF_OUT_EN:   rdata = out_en_r;
      `TCS_OFF_STRONG:   rdata = strong_r;
      `TCS_OFF_SETTLE:   rdata = settle_r;
      `TCS_OFF_OTHER:    rdata = other_r;
      `TCS_OFF_SCAN0:    rdata = scan0_r;
      `TCS_OFF_SCAN1:    rdata = scan1_r;
      `TCS_OFF_ADDR_DM:  rdata = addr_dm_r;
      `TCS_OFF_STATUS:   rdata = {6'h00, scan_en, setup_mode};
      `TCS_OFF_BUTTONS:  rdata = {6'h00, sense_state};
      default:           rdata = 8'h00;
    endcase
  end

  // Outputs: both pins sensor-driven or both register-driven, masked per pin by out_en_r
  always @(posedge clk)
  begin
    if (!rst_n)
      out_pins <= 2'b00;
    else if (addr_dm_r[`TCS_ADDR_DM_SRC_BIT])
      out_pins <= sense_state & out_en_r[1:0];
    else
      out_pins <= out_port_r[1:0] & out_en_r[1:0];
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_d_r      <= 1'b1;
      sda_d_r      <= 1'b1;
      st_r         <= ST_IDLE;
      bit_r        <= 3'd0;
      sh_r         <= 8'h00;
      first_r      <= 1'b0;
      rd_r         <= 1'b0;
      ptr_ok_r     <= 1'b0;
      ptr_r        <= 8'h00;
      hit_r        <= 1'b0;
      sda_low_r    <= 1'b0;
      hold_start_r <= 1'b0;
      sense_en_r   <= `TCS_RST_SENSE_EN;
      out_en_r     <= `TCS_RST_OUT_EN;
      strong_r     <= `TCS_RST_STRONG;
      settle_r     <= `TCS_RST_SETTLE;
      other_r      <= `TCS_RST_OTHER;
      scan0_r      <= `TCS_RST_SCAN0;
      scan1_r      <= `TCS_RST_SCAN1;
      out_port_r   <= `TCS_RST_OUT_PORT;
      addr_dm_r    <= `TCS_RST_ADDR_DM;
      scan_en      <= 1'b1;
      setup_mode   <= 1'b0;
      save_req     <= 1'b0;
    end
    else
    begin
      scl_d_r      <= scl_s;
      sda_d_r      <= sda_s;
      hold_start_r <= 1'b0;
      if (save_done)
        save_req <= 1'b0;
      // Stored image reloaded at power-up
      if (load_valid)
      begin
        sense_en_r <= load_image[7:0];
        out_en_r   <= load_image[15:8];
        strong_r   <= load_image[23:16];
        settle_r   <= load_image[31:24];
        other_r    <= load_image[39:32];
        scan0_r    <= load_image[47:40];
        scan1_r    <= load_image[55:48];
        addr_dm_r  <= load_image[63:56];
      end
      if (stop_c)
      begin
        st_r      <= ST_IDLE;
        sda_low_r <= 1'b0;
      end
      else if (start_c)
      begin
        st_r      <= ST_RX;
        bit_r     <= 3'd0;
        first_r   <= 1'b1;
        ptr_ok_r  <= 1'b0;
        sda_low_r <= 1'b0;
      end
      else
      begin
        case (st_r)
          ST_IDLE: ;
          ST_RX:
          begin
            if (scl_rise)
            begin
              sh_r  <= {sh_r[6:0], sda_s};
              bit_r <= bit_r + 3'd1;
              if (bit_r == 3'd7)
                st_r <= ST_HOLD;
            end
          end
          ST_HOLD:
          begin
            if (scl_fall)
              hold_start_r <= 1'b1;
            else if (!scl_s && !hold_busy && !hold_start_r)
            begin
              st_r <= ST_ACK;
              if (first_r)
              begin
                // Address match against bus-programmable address
                hit_r     <= (sh_r[7:1] == addr_dm_r[6:0]);
                rd_r      <= sh_r[0];
                sda_low_r <= (sh_r[7:1] == addr_dm_r[6:0]);
                first_r   <= 1'b0;
              end
              else
              begin
                sda_low_r <= 1'b1;
                if (!ptr_ok_r)
                begin
                  ptr_r    <= sh_r;
                  ptr_ok_r <= 1'b1;
                end
                else
                begin
                  case (ptr_r)
                    // Setup-only registers kept in normal mode, still acked
                    `TCS_OFF_SENSE_EN: if (setup_mode) sense_en_r <= sh_r;
                    `TCS_OFF_OUT_EN:   if (setup_mode) out_en_r   <= sh_r;
                    `TCS_OFF_STRONG:   if (setup_mode) strong_r   <= sh_r;
                    `TCS_OFF_SETTLE:   if (setup_mode) settle_r   <= sh_r;
                    `TCS_OFF_OTHER:    if (setup_mode) other_r    <= sh_r;
                    `TCS_OFF_SCAN0:    if (setup_mode) scan0_r    <= sh_r;
                    `TCS_OFF_SCAN1:    if (setup_mode) scan1_r    <= sh_r;
                    `TCS_OFF_OUT_PORT: out_port_r <= sh_r;
                    `TCS_OFF_ADDR_DM:  addr_dm_r  <= sh_r;
                    `TCS_OFF_CMD:
                    begin
                      if (sh_r == `TCS_CMD_STOP_SCAN)
                        scan_en <= 1'b0;
                      else if (sh_r == `TCS_CMD_START_SCAN)
                        scan_en <= 1'b1;
                      else if (sh_r == `TCS_CMD_SETUP_ENTER)
                        setup_mode <= 1'b1;
                      else if (sh_r == `TCS_CMD_SETUP_LEAVE)
                        setup_mode <= 1'b0;
                      else if (sh_r == `TCS_CMD_SAVE)
                        save_req <= 1'b1;
                    end
                    default: ;
                  endcase
                  ptr_r <= ptr_r + 8'h01;
                end
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              sda_low_r <= 1'b0;
              bit_r     <= 3'd0;
              if (!hit_r)
                st_r <= ST_IDLE;
              else if (rd_r)
              begin
                st_r      <= ST_TX;
                sh_r      <= {rdata[6:0], 1'b0};
                sda_low_r <= ~rdata[7];
                ptr_r     <= ptr_r + 8'h01;
              end
              else
                st_r <= ST_RX;
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              bit_r <= bit_r + 3'd1;
              if (bit_r == 3'd7)
              begin
                sda_low_r <= 1'b0;
                st_r      <= ST_RACK;
              end
              else
              begin
                sda_low_r <= ~sh_r[7];
                sh_r      <= {sh_r[6:0], 1'b0};
              end
            end
          end
          ST_RACK:
          begin
            if (scl_rise)
              st_r <= sda_s ? ST_IDLE : ST_ACK;
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // tcs_slave
`default_nettype wire

//--- tcs_master.sv
// Two-wire bus master model driving the slave port pins
`default_nettype none
module tcs_master
(
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output var logic  m_scl,
  output var logic  m_sda,
  output var logic  hung,
  output var int    hold_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    m_scl = 1'b1;
    m_sda = 1'b1;
    hung = 1'b0;
    hold_n = 0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Release SCL and wait out any stretch; bit period near 800 ns
  // hold_n keeps the length of the last stretch seen
  task automatic rise();
    int k;
    m_scl = 1'b1;
    k = 1;
    tick(1);
    // Wait bound lies above the longest per-byte delay
    while (scl !== 1'b1 && k < 30000)
    begin
      tick(1);
      k++;
    end
    if (k > 1) hold_n = k;
    if (k == 30000) hung = 1'b1;
    tick(3);
  endtask
  task automatic bit_io(input logic b, output logic s);
    m_sda = b;
    tick(2);
    rise();
    s = sda;
    m_scl = 1'b0;
    tick(2);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(mack, ack);
  endtask
  // Opens only once SCL reads high and the last acknowledge is over
  task automatic start();
    m_sda = 1'b1;
    tick(2);
    rise();
    m_sda = 1'b0;
    tick(2);
    m_scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    m_sda = 1'b0;
    tick(2);
    rise();
    m_sda = 1'b1;
    tick(4);
  endtask
endmodule // tcs_master
`default_nettype wire

//--- tcs_slave_asserts.sv
// Checker of the touch controller slave port pins
`default_nettype none
module tcs_slave_asserts
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic scan_en,
  input wire logic setup_mode,
  input wire logic save_req,
  input wire logic save_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_r;
  logic        long_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Length of the current hold, and whether the long figure applies to it
  always @(posedge clk)
  begin
    cnt_r <= scl_oe_n ? 16'h0000 : cnt_r + 16'h0001;
    long_r <= scl_oe_n ? (setup_mode && scan_en) : long_r;
  end
  a_norm_hold_len: assert property (
    $rose(scl_oe_n) && !long_r |-> cnt_r inside {[195:205]})
    else $error("short acknowledge hold has wrong length");
  a_setup_hold_len: assert property (
    $rose(scl_oe_n) && long_r |-> cnt_r inside {[19990:20010]})
    else $error("setup acknowledge hold has wrong length");
  a_hold_min: assert property ($fell(scl_oe_n) |-> !scl_oe_n [*8])
    else $error("clock hold released too early");
  a_hold_pulls_low: assert property (!scl_oe_n |-> !scl_o)
    else $error("clock hold does not pull low");
  a_hold_after_fall: assert property ($fell(scl_oe_n) |-> !$past(scl_i))
    else $error("clock hold started while clock high");
  a_sda_on_low: assert property ($changed(sda_oe_n) |-> !$past(scl_i))
    else $error("data line changed while clock high");
  a_save_hold: assert property (save_req && !save_done |=> save_req)
    else $error("store request dropped early");
  a_save_drop: assert property (save_req && save_done |=> !save_req)
    else $error("store request kept after done");
  a_idle_reset: assert property ($rose(rst_n) |-> scl_oe_n && sda_oe_n && scan_en && !setup_mode)
    else $error("pins or modes wrong after reset");
  c_long_hold: cover property ($rose(scl_oe_n) && long_r);
  c_ack_no_scan: cover property ($fell(sda_oe_n) && !scan_en);
  c_save: cover property (save_req && save_done);
endmodule // tcs_slave_asserts
bind tcs_slave tcs_slave_asserts i_chk (.clk, .rst_n, .scl_i, .scl_o, .scl_oe_n, .sda_oe_n,
  .scan_en, .setup_mode, .save_req, .save_done);
`default_nettype wire

//--- tcs_slave_tb.sv
// Self-checking bench of the touch controller slave port
`default_nettype none
module tcs_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, m_scl, m_sda, hung, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic        scan_en, setup_mode, save_req, save_done, load_valid, a0, a1, a2, ax;
  logic [1:0]  sense_state, out_pins;
  logic [7:0]  rx, rd, dev;
  logic [63:0] load_image;
  int          hold_n;
  int          n_errors = 0;
  int          total_checks = 0;
  int          save_cnt = 0;
  wire logic   scl = m_scl & (scl_oe_n | scl_o);
  wire logic   sda = m_sda & (sda_oe_n | sda_o);
  // Offset and reset value; each row writes the inverse of the reset value
  logic [15:0] rows [7] = '{16'h0703, 16'h0803, 16'h1103, 16'h50a0, 16'h5100, 16'h5c00, 16'h5d01};
  tcs_master i_mst (.clk, .scl, .sda, .m_scl, .m_sda, .hung, .hold_n);
  tcs_slave i_dut (.clk, .rst_n, .scl_i(scl), .scl_o, .scl_oe_n, .sda_i(sda), .sda_o, .sda_oe_n,
    .sense_state, .out_pins, .scan_en, .setup_mode, .save_req, .save_done, .load_valid,
    .load_image);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] r, input logic [7:0] d);
    i_mst.start();
    i_mst.xfer({dev[6:0], 1'b0}, 1'b1, rx, a0);
    i_mst.xfer(r, 1'b1, rx, a1);
    i_mst.xfer(d, 1'b1, rx, a2);
    i_mst.stop();
    check({7'h00, a0 | a1 | a2}, 8'h00);
  endtask
  task automatic rreg(input logic [7:0] r, output logic [7:0] d);
    i_mst.start();
    i_mst.xfer({dev[6:0], 1'b0}, 1'b1, rx, a0);
    i_mst.xfer(r, 1'b1, rx, a1);
    i_mst.start();
    i_mst.xfer({dev[6:0], 1'b1}, 1'b1, rx, a2);
    check({7'h00, a0 | a1 | a2}, 8'h00);
    i_mst.xfer(8'hff, 1'b1, d, ax);
    i_mst.stop();
  endtask
  task automatic addr_only(input logic [7:0] a);
    i_mst.start();
    i_mst.xfer(a, 1'b1, rx, a0);
    i_mst.stop();
  endtask
  task automatic run_rows(input logic setup);
    for (int i = 0; i < 7; i++)
    begin
      wreg(rows[i][15:8], ~rows[i][7:0]);
      rreg(rows[i][15:8], rd);
      check(rd, setup ? ~rows[i][7:0] : rows[i][7:0]);
    end
    check({7'h00, hold_n < 300}, 8'h01);
    $display("register rows done, setup %0d", setup);
  endtask
  always @(posedge hung)
  begin
    n_errors++;
    stop_test();
  end
  // Storage model: finishes a store some cycles after it is asked for
  always @(posedge clk)
  begin
    save_cnt <= save_req ? save_cnt + 1 : 0;
    save_done <= #1 (save_cnt == 40);
  end
  initial
  begin
    rst_n = 1'b0;
    sense_state = 2'b00;
    load_valid = 1'b0;
    load_image = 64'h0;
    dev = 8'h00;
    i_mst.tick(6);
    rst_n = 1'b1;
    check({3'h0, scl_oe_n, sda_oe_n, scan_en, setup_mode, save_req}, 8'h1c);
    i_mst.tick(3);
    $display("reset test done");
    run_rows(1'b0);
    addr_only(8'h24);
    check({7'h00, a0}, 8'h01);
    sense_state = 2'b10;
    i_mst.tick(4);
    check({6'h00, out_pins}, 8'h02);
    sense_state = 2'b01;
    i_mst.tick(4);
    check({6'h00, out_pins}, 8'h01);
    wreg(8'h04, 8'h02);
    wreg(8'h7c, 8'h2a);
    check({6'h00, out_pins}, 8'h02);
    dev = 8'h2a;
    rreg(8'h7c, rd);
    check(rd, 8'h2a);
    addr_only(8'h00);
    check({7'h00, a0}, 8'h01);
    $display("output and address tests done");
    wreg(8'ha0, 8'h0a);
    check({7'h00, scan_en}, 8'h00);
    wreg(8'ha0, 8'h08);
    rreg(8'h7b, rd);
    check(rd, 8'h01);
    run_rows(1'b1);
    wreg(8'ha0, 8'h07);
    rreg(8'h7b, rd);
    check(rd, 8'h00);
    rreg(8'h88, rd);
    check(rd, 8'h01);
    check({7'h00, hold_n < 300}, 8'h01);
    wreg(8'ha0, 8'h08);
    wreg(8'ha0, 8'h01);
    check({7'h00, save_req}, 8'h01);
    i_mst.tick(50);
    check({7'h00, save_req}, 8'h00);
    sense_state = 2'b11;
    load_image = 64'h80010000a003035a;
    load_valid = 1'b1;
    i_mst.tick(1);
    load_valid = 1'b0;
    i_mst.tick(2);
    dev = 8'h00;
    rreg(8'h07, rd);
    check(rd, 8'h5a);
    check({6'h00, out_pins}, 8'h03);
    $display("store and reload tests done");
    wreg(8'ha0, 8'h0b);
    addr_only(8'h00);
    check({7'h00, hold_n > 19000}, 8'h01);
    $display("long hold test done");
    stop_test();
  end
endmodule // tcs_slave_tb
`default_nettype wire
